// ==== ccs_pkg.sv ====
// Purpose: constants for the capacitive channel conversion setup block
// Assumes: 16-bit registers reached over a simple byte-addressed port
// Notes: offsets are register addresses as seen by the host
package ccs_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_REF_COUNT_CH0 = 8'h08;
   localparam logic [7:0] OFS_SENSOR_DRIVE_CH0 = 8'h0E;
   localparam logic [7:0] OFS_SETTLING_INTERVAL_CH0 = 8'h10;
   localparam logic [7:0] OFS_FREQ_DIVIDER_CH0 = 8'h14;
   localparam logic [7:0] OFS_FAULT_REPORT_SETUP = 8'h19;
   localparam logic [7:0] OFS_MAIN_CONFIG = 8'h1A;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int FIN_SEL_LSB = 12;
   localparam int FIN_SEL_W = 2;
   localparam int FREF_DIV_W = 10;
   localparam int DRIVE_CODE_LSB = 11;
   localparam int DRIVE_CODE_W = 5;
   localparam int INIT_DRIVE_LSB = 6;
   localparam int INIT_DRIVE_W = 5;
   localparam int SLEEP_BIT = 13;
   localparam logic [1:0] FIN_SEL_DIV2 = 2'h2;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_REF_COUNT = 16'h0080;
   localparam logic [15:0] RST_SENSOR_DRIVE = 16'h0000;
   localparam logic [15:0] RST_SETTLING = 16'h0000;
   localparam logic [15:0] RST_FREQ_DIVIDER = 16'h0000;
   localparam logic [15:0] RST_FAULT_REPORT = 16'h0000;
   localparam logic [15:0] RST_MAIN_CONFIG = 16'h2801;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int PERIOD_MULT = 16;
   localparam int SWITCH_DELAY_NS = 1000;
   localparam int REF_PERIOD_NS = 25;
   localparam int SWITCH_DELAY_REFS = SWITCH_DELAY_NS / REF_PERIOD_NS;
   typedef enum logic [1:0] {ST_SLEEP, ST_SWITCH, ST_SETTLE, ST_CONVERT}
      ccs_state_e;
endpackage

// ==== ccs_channel_setup.sv ====
// Purpose: register file and conversion timing for one sensing channel
// Assumes: ref_clk_in and sensor_osc_in are async pins, sampled here
// Notes: reference and sensor clocks are counted as edges, not used as clocks
//
// How it works
// RL1: comes up asleep, no conversions
// RL2: select b10 halves the sensor input
// RL3: reference divided by divisor, 1 passes
// RL4: divider register packs select and divisor
// RL5: host keeps reference above four times sensor
// RL6: settling lasts settle count times 16 refs
// RL7: conversion lasts ref count times 16 divided refs
// RL8: switching delay before each settling
// RL9: settle count held at 0x10
// RL10: conversion count held at 0x08
// RL11: drive register holds code and initial drive
// RL12: fault reporting resets with all disabled
// RL13: host writes main configuration last
// RL14: clearing sleep bit starts conversions
// RL15: configuration writes accepted while asleep
`timescale 1ns/10ps
`default_nettype none
module ccs_channel_setup
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata_r,
   output logic reg_refused_r,
   // sensor side pins
   input wire logic ref_clk_in,
   input wire logic sensor_osc_in,
   output logic [4:0] sensor_drive_code_r,
   output logic conv_active_r,
   output logic settling_r,
   output logic conv_done_r,
   output logic [27:0] sensor_count_r
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] ref_count_ch0_r;
   logic [15:0] sensor_drive_ch0_r;
   logic [15:0] settling_interval_ch0_r;
   logic [15:0] freq_divider_ch0_r;
   logic [15:0] fault_report_setup_r;
   logic [15:0] main_config_r;
   ccs_pkg::ccs_state_e state_r;
   logic asleep;
   // configuration refused once awake; sleep control is always writable
   assign asleep = main_config_r[ccs_pkg::SLEEP_BIT];
   // RL15: writes accepted asleep
   // RL9: settle count storage
   // RL10: conversion count storage
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ref_count_ch0_r <= ccs_pkg::RST_REF_COUNT;
         sensor_drive_ch0_r <= ccs_pkg::RST_SENSOR_DRIVE;
         settling_interval_ch0_r <= ccs_pkg::RST_SETTLING;
         freq_divider_ch0_r <= ccs_pkg::RST_FREQ_DIVIDER;
         // RL12: interrupts disabled
         fault_report_setup_r <= ccs_pkg::RST_FAULT_REPORT;
         // RL1: sleep after reset
         main_config_r <= ccs_pkg::RST_MAIN_CONFIG;
         reg_refused_r <= 1'b0;
      end
      else
      begin
         reg_refused_r <= 1'b0;
         if (reg_wr)
         begin
            if (reg_addr == ccs_pkg::OFS_MAIN_CONFIG)
               main_config_r <= reg_wdata;
            else if (!asleep)
               reg_refused_r <= 1'b1;
            else
            begin
               case (reg_addr)
                  ccs_pkg::OFS_REF_COUNT_CH0: ref_count_ch0_r <= reg_wdata;
                  ccs_pkg::OFS_SENSOR_DRIVE_CH0:
                     sensor_drive_ch0_r <= reg_wdata;
                  ccs_pkg::OFS_SETTLING_INTERVAL_CH0:
                     settling_interval_ch0_r <= reg_wdata;
                  // RL4: packed divider fields
                  ccs_pkg::OFS_FREQ_DIVIDER_CH0:
                     freq_divider_ch0_r <= reg_wdata;
                  ccs_pkg::OFS_FAULT_REPORT_SETUP:
                     fault_report_setup_r <= reg_wdata;
                  default: reg_refused_r <= 1'b1;
               endcase
            end
         end
      end
   end
   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         reg_rdata_r <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            ccs_pkg::OFS_REF_COUNT_CH0: reg_rdata_r <= ref_count_ch0_r;
            ccs_pkg::OFS_SENSOR_DRIVE_CH0: reg_rdata_r <= sensor_drive_ch0_r;
            ccs_pkg::OFS_SETTLING_INTERVAL_CH0:
               reg_rdata_r <= settling_interval_ch0_r;
            ccs_pkg::OFS_FREQ_DIVIDER_CH0: reg_rdata_r <= freq_divider_ch0_r;
            ccs_pkg::OFS_FAULT_REPORT_SETUP:
               reg_rdata_r <= fault_report_setup_r;
            ccs_pkg::OFS_MAIN_CONFIG: reg_rdata_r <= main_config_r;
            default: reg_rdata_r <= 16'h0000;
         endcase
      end
   end
   // ------------------------------------------------------------
   // pin synchronisers and edge detect
   // ------------------------------------------------------------
   logic [2:0] ref_sync_r;
   logic [2:0] osc_sync_r;
   logic ref_level_r;
   logic osc_level_r;
   logic ref_rise;
   logic osc_rise;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ref_sync_r <= 3'h0;
         osc_sync_r <= 3'h0;
         ref_level_r <= 1'b0;
         osc_level_r <= 1'b0;
      end
      else
      begin
         ref_sync_r <= {ref_sync_r[1:0], ref_clk_in};
         osc_sync_r <= {osc_sync_r[1:0], sensor_osc_in};
         // stage 0 only feeds stage 1; filter looks at stages 1 and 2
         if (ref_sync_r[1] == ref_sync_r[2])
            ref_level_r <= ref_sync_r[2];
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_level_r <= osc_sync_r[2];
      end
   end
   assign ref_rise = (ref_sync_r[1] == ref_sync_r[2]) && ref_sync_r[2]
      && !ref_level_r;
   assign osc_rise = (osc_sync_r[1] == osc_sync_r[2]) && osc_sync_r[2]
      && !osc_level_r;
   // ------------------------------------------------------------
   // reference divider and sensor input divide
   // ------------------------------------------------------------
   logic [9:0] fref_cnt_r;
   logic ref_tick_r;
   logic [9:0] divisor;
   assign divisor = freq_divider_ch0_r[ccs_pkg::FREF_DIV_W-1:0];
   // RL3: divide reference clock
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fref_cnt_r <= 10'h000;
         ref_tick_r <= 1'b0;
      end
      else
      begin
         ref_tick_r <= 1'b0;
         // phase restarts so each conversion spans whole periods
         if (state_r != ccs_pkg::ST_CONVERT)
            fref_cnt_r <= 10'h000;
         else if (ref_rise)
         begin
            if (fref_cnt_r + 10'h001 >= divisor)
            begin
               fref_cnt_r <= 10'h000;
               ref_tick_r <= 1'b1;
            end
            else
               fref_cnt_r <= fref_cnt_r + 10'h001;
         end
      end
   end
   logic osc_half_r;
   logic osc_tick;
   // RL2: b10 divides sensor by two
   assign osc_tick = osc_rise &&
      ((freq_divider_ch0_r[ccs_pkg::FIN_SEL_LSB +: ccs_pkg::FIN_SEL_W]
        != ccs_pkg::FIN_SEL_DIV2) || osc_half_r);
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         osc_half_r <= 1'b0;
      else if (osc_rise)
         osc_half_r <= !osc_half_r;
   end
   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   logic [19:0] len_cnt_r;
   logic [19:0] settle_len;
   logic [19:0] conv_len;
   // RL6: settle count times 16
   assign settle_len = {settling_interval_ch0_r, 4'h0};
   // RL7: ref count times 16
   assign conv_len = {ref_count_ch0_r, 4'h0};
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_r <= ccs_pkg::ST_SLEEP;
         len_cnt_r <= 20'h0_0000;
         conv_done_r <= 1'b0;
         sensor_count_r <= 28'h000_0000;
      end
      else
      begin
         conv_done_r <= 1'b0;
         // RL14: leaving sleep starts work
         if (asleep)
         begin
            state_r <= ccs_pkg::ST_SLEEP;
            len_cnt_r <= 20'h0_0000;
         end
         else
         begin
            case (state_r)
               ccs_pkg::ST_SLEEP:
               begin
                  state_r <= ccs_pkg::ST_SWITCH;
                  len_cnt_r <= 20'h0_0000;
               end
               // RL8: channel switching delay
               ccs_pkg::ST_SWITCH:
                  if (ref_rise)
                  begin
                     if (len_cnt_r + 20'h0_0001 >=
                        20'(ccs_pkg::SWITCH_DELAY_REFS))
                     begin
                        state_r <= ccs_pkg::ST_SETTLE;
                        len_cnt_r <= 20'h0_0000;
                     end
                     else
                        len_cnt_r <= len_cnt_r + 20'h0_0001;
                  end
               ccs_pkg::ST_SETTLE:
                  if (len_cnt_r >= settle_len)
                  begin
                     state_r <= ccs_pkg::ST_CONVERT;
                     len_cnt_r <= 20'h0_0000;
                     sensor_count_r <= 28'h000_0000;
                  end
                  else if (ref_rise)
                     len_cnt_r <= len_cnt_r + 20'h0_0001;
               ccs_pkg::ST_CONVERT:
               begin
                  if (osc_tick)
                     sensor_count_r <= sensor_count_r + 28'h000_0001;
                  if (len_cnt_r >= conv_len)
                  begin
                     conv_done_r <= 1'b1;
                     state_r <= ccs_pkg::ST_SWITCH;
                     len_cnt_r <= 20'h0_0000;
                  end
                  else if (ref_tick_r)
                     len_cnt_r <= len_cnt_r + 20'h0_0001;
               end
               default: state_r <= ccs_pkg::ST_SLEEP;
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // drive outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         conv_active_r <= 1'b0;
         settling_r <= 1'b0;
         sensor_drive_code_r <= 5'h00;
      end
      else
      begin
         conv_active_r <= (state_r == ccs_pkg::ST_CONVERT);
         settling_r <= (state_r == ccs_pkg::ST_SETTLE);
         // RL11: drive code field
         sensor_drive_code_r <= sensor_drive_ch0_r[ccs_pkg::DRIVE_CODE_LSB
            +: ccs_pkg::DRIVE_CODE_W];
      end
   end
endmodule // ccs_channel_setup
`default_nettype wire

// ==== ccs_pin_source.sv ====
// Purpose: reference and sensor oscillation pins for the bench
// Assumes: 40 MHz reference, 8 MHz sensor tank
// Notes: both free running, unrelated to sys_clk
`timescale 1ns/10ps
`default_nettype none
module ccs_pin_source
(
   // pins
   output var logic ref_clk,
   output var logic osc
);
   initial
   begin
      ref_clk = 1'b0;
      osc = 1'b0;
   end
   always #12.5 ref_clk = ~ref_clk;
   always #62.5 osc = ~osc;
endmodule // ccs_pin_source
`default_nettype wire

// ==== ccs_assertions.sv ====
// Purpose: port checks for the channel setup block
// Assumes: main config at its package offset
// Notes: sleep tracked from host writes
`timescale 1ns/10ps
`default_nettype none
module ccs_assertions
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_r,
   input wire logic reg_refused_r,
   // sensor side
   input wire logic [4:0] sensor_drive_code_r,
   input wire logic conv_active_r,
   input wire logic settling_r,
   input wire logic conv_done_r
);
   logic asleep_r, mapped;
   logic [2:0] sleep_cnt_r;
   logic [7:0] idle_cnt_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   always_comb mapped = reg_addr inside {ccs_pkg::OFS_REF_COUNT_CH0,
      ccs_pkg::OFS_SENSOR_DRIVE_CH0, ccs_pkg::OFS_SETTLING_INTERVAL_CH0,
      ccs_pkg::OFS_FREQ_DIVIDER_CH0, ccs_pkg::OFS_FAULT_REPORT_SETUP,
      ccs_pkg::OFS_MAIN_CONFIG};
   always_ff @(posedge sys_clk)
      if (sys_rst) asleep_r <= 1'b1;
      else if (reg_wr && reg_addr == ccs_pkg::OFS_MAIN_CONFIG)
         asleep_r <= reg_wdata[ccs_pkg::SLEEP_BIT];
   // settle margin: outputs lag the state by a couple of edges
   always_ff @(posedge sys_clk)
      if (sys_rst || !asleep_r) sleep_cnt_r <= 3'h0;
      else if (sleep_cnt_r != 3'h7) sleep_cnt_r <= sleep_cnt_r + 3'h1;
   always_ff @(posedge sys_clk)
      if (sys_rst || conv_active_r || settling_r) idle_cnt_r <= 8'h00;
      else if (idle_cnt_r != 8'hFF) idle_cnt_r <= idle_cnt_r + 8'h01;
   sequence s_wr_bad;
      reg_wr && !mapped;
   endsequence
   sequence s_wr_run;
      !asleep_r && reg_wr && reg_addr != ccs_pkg::OFS_MAIN_CONFIG;
   endsequence
   chk_sleep_quiet: assert property (sleep_cnt_r >= 3'h3 |->
      !conv_active_r && !settling_r) else $error("active while asleep");
   chk_phase_excl: assert property (!(conv_active_r && settling_r))
      else $error("settle and convert overlap");
   chk_done_pulse: assert property (conv_done_r |=> !conv_done_r)
      else $error("done longer than one cycle");
   chk_conv_follows: assert property ($fell(settling_r) && !asleep_r
      |-> ##[0:3] conv_active_r) else $error("no conversion after settle");
   chk_switch_gap: assert property ($rose(settling_r)
      |-> idle_cnt_r >= 8'hBE) else $error("switch delay short");
   chk_unmapped_wr: assert property (s_wr_bad |=> reg_refused_r)
      else $error("unmapped write taken");
   chk_sleep_accept: assert property (asleep_r && reg_wr && mapped
      |=> !reg_refused_r) else $error("write refused asleep");
   chk_run_refuse: assert property (s_wr_run |=> reg_refused_r)
      else $error("write taken while running");
   chk_unmapped_rd: assert property (reg_rd && !mapped
      |=> reg_rdata_r == 16'h0000) else $error("unmapped read not zero");
   chk_drive_code: assert property (asleep_r && reg_wr &&
      reg_addr == ccs_pkg::OFS_SENSOR_DRIVE_CH0 |-> ##2
      sensor_drive_code_r == $past(reg_wdata[15:11], 2))
      else $error("drive code not stored");
endmodule // ccs_assertions
bind ccs_channel_setup ccs_assertions u_chk (.sys_clk, .sys_rst, .reg_wr,
   .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r, .reg_refused_r,
   .sensor_drive_code_r, .conv_active_r, .settling_r, .conv_done_r);
`default_nettype wire

// ==== tb.sv ====
// Purpose: register and timing test of the channel setup block
// Assumes: 200 MHz sys_clk, inputs driven at falling edge
// Notes: durations checked in reference periods of 5 clocks
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
   miscompares++; $display("Error %s exp %0h got %0h", nm, e, a); end end
module tb;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata_r;
   logic reg_refused_r, ref_clk_in, sensor_osc_in;
   logic conv_active_r, settling_r, conv_done_r;
   logic [4:0] sensor_drive_code_r;
   logic [27:0] sensor_count_r;
   int miscompares = 0, comparisons = 0, w, c, i, dones = 0;
   logic [7:0] adr[7] = '{8'h08, 8'h0E, 8'h10, 8'h14, 8'h19, 8'h1A, 8'h33};
   logic [15:0] rv[7] = '{16'h0080, 0, 0, 0, 0, 16'h2801, 0};
   always #2.5 sys_clk = ~sys_clk;
   // end pulses counted while they stand
   always @(negedge sys_clk)
      if (conv_done_r === 1'b1)
         dones++;
   ccs_pin_source SRC (.ref_clk(ref_clk_in), .osc(sensor_osc_in));
   ccs_channel_setup DUT (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata_r, .reg_refused_r, .ref_clk_in, .sensor_osc_in,
      .sensor_drive_code_r, .conv_active_r, .settling_r, .conv_done_r,
      .sensor_count_r);
   task end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d, input logic rf);
      @(negedge sys_clk);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      `CHK("refused", rf, reg_refused_r)
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge sys_clk);
      reg_rd = 1'b1; reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      `CHK("rdata", e, reg_rdata_r)
   endtask
   // wait for a phase, then time it; k 0 settle, 1 convert
   task dur(input int k, output int wt, output int n);
      wt = 0; n = 0;
      while (!(k ? conv_active_r : settling_r) && wt < 5000)
      begin wt++; @(negedge sys_clk); end
      if (wt == 5000)
      begin miscompares++; end_sim; end
      while ((k ? conv_active_r : settling_r) && n < 5000)
      begin n++; @(negedge sys_clk); end
      if (n == 5000)
      begin
         miscompares++;
         end_sim;
      end
   endtask
   initial
   begin
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (300) @(negedge sys_clk);
      `CHK("asleep", 2'b00, {conv_active_r, settling_r})
      for (i = 0; i < 7; i++) rd(adr[i], rv[i]);
      wr(8'h33, 16'h1234, 1'b1);
      wr(ccs_pkg::OFS_FREQ_DIVIDER_CH0, 16'h2001, 1'b0);
      rd(ccs_pkg::OFS_FREQ_DIVIDER_CH0, 16'h2001);
      wr(ccs_pkg::OFS_SENSOR_DRIVE_CH0, 16'h7C00, 1'b0);
      @(negedge sys_clk);
      `CHK("drive", 5'h0F, sensor_drive_code_r)
      wr(ccs_pkg::OFS_SETTLING_INTERVAL_CH0, 16'h0002, 1'b0);
      wr(ccs_pkg::OFS_REF_COUNT_CH0, 16'h0002, 1'b0);
      wr(ccs_pkg::OFS_MAIN_CONFIG, 16'h0801, 1'b0);
      dur(0, w, c);
      `CHK("switch", 1'b1, w >= 190 && w <= 215)
      `CHK("settle", 32, (c + 2) / 5)
      dur(1, w, c);
      `CHK("conv", 32, (c + 2) / 5)
      repeat (2) @(negedge sys_clk);
      `CHK("halved", 1'b1, sensor_count_r inside {[2:4]})
      `CHK("done", 1, dones)
      wr(ccs_pkg::OFS_SETTLING_INTERVAL_CH0, 16'h0005, 1'b1);
      wr(ccs_pkg::OFS_MAIN_CONFIG, 16'h2801, 1'b0);
      repeat (10) @(negedge sys_clk);
      `CHK("resleep", 2'b00, {conv_active_r, settling_r})
      wr(ccs_pkg::OFS_FREQ_DIVIDER_CH0, 16'h0002, 1'b0);
      wr(ccs_pkg::OFS_MAIN_CONFIG, 16'h0801, 1'b0);
      dur(0, w, c);
      dur(1, w, c);
      `CHK("conv_div2", 64, (c + 2) / 5)
      repeat (2) @(negedge sys_clk);
      `CHK("full", 1'b1, sensor_count_r inside {[11:14]})
      `CHK("done2", 2, dones)
      end_sim;
   end
endmodule // tb
`default_nettype wire
